// file: pkg/block_xfer_pkg.sv
// Shared constants, types and helper functions of the block transfer sequencer.
package block_xfer_pkg;
	typedef logic [31:0] word_t;
	typedef logic [3:0] reg_idx_t;
	typedef logic [15:0] reg_list_t;
	typedef logic [4:0] cycle_t;
	typedef logic [1:0] rsp_t;
	typedef logic [15:0][31:0] reg_bank_t;

	localparam reg_idx_t PROGRAM_COUNTER_IDX = 4'hF;
	localparam int LAST_REG = 15;
	localparam word_t WORD_STEP = 32'h0000_0004;
	localparam word_t PAIR_STEP = 32'h0000_0008;
	localparam word_t NO_STEP = 32'h0000_0000;
	localparam word_t PC_STORE_OFFSET = 32'h0000_0008;
	localparam word_t PC_ALIGN_MASK = 32'hFFFF_FFFC;
	localparam cycle_t MIN_CYCLES = 5'h02;
	localparam cycle_t CYCLE_ONE = 5'h01;
	localparam cycle_t PC_EXTRA_DOUBLE = 5'h04;
	localparam cycle_t PC_EXTRA_SINGLE = 5'h05;
	localparam rsp_t RSP_NONE = 2'h0;
	localparam rsp_t RSP_ONE = 2'h1;
	localparam rsp_t RSP_TWO = 2'h2;

	typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RUN = 2'b10} seq_state_t;

	// Returns the hit flag and the index of the lowest set bit.
	function automatic logic [4:0] lowestSet(input reg_list_t m);
		logic [4:0] res;
		res = 5'h00;
		for (int i = LAST_REG; i >= 0; i--)
		begin
			if (m[i])
			begin
				res = {1'b1, 4'(i)};
			end
		end
		return res;
	endfunction

	function automatic reg_list_t regBit(input reg_idx_t idx);
		return reg_list_t'(16'h0001 << idx);
	endfunction
endpackage

// file: rtl/block_addr_calc.sv
// Start address, final base and least cycle count of one block transfer.
module block_addr_calc
(
	// Decoded instruction
	input wire block_xfer_pkg::word_t baseValue,
	input wire block_xfer_pkg::cycle_t totalCount,
	input wire block_xfer_pkg::cycle_t ordinaryCount,
	input wire logic pcSelected,
	input wire logic preIndex,
	input wire logic up,
	input wire logic loadMultiple,
	input wire logic doubleBw,
	// Results
	output block_xfer_pkg::word_t startAddr,
	output block_xfer_pkg::word_t finalBase,
	output block_xfer_pkg::cycle_t targetCycles
);
	import block_xfer_pkg::*;

	word_t span;
	cycle_t halfUp;

	function automatic cycle_t atLeastTwo(input cycle_t c);
		return (c < MIN_CYCLES) ? MIN_CYCLES : c;
	endfunction

	always_comb
	begin
		span = word_t'({totalCount, 2'b00});
		// Steps are whole words, so the two low base bits pass unchanged.
		if (up)
		begin
			startAddr = preIndex ? baseValue + WORD_STEP : baseValue;
			finalBase = baseValue + span;
		end
		else
		begin
			startAddr = preIndex ? baseValue - span
				: baseValue - span + WORD_STEP;
			finalBase = baseValue - span;
		end
		halfUp = cycle_t'((ordinaryCount + CYCLE_ONE) >> 1);
		if (!loadMultiple)
		begin
			targetCycles = atLeastTwo(totalCount);
		end
		else if (doubleBw)
		begin
			targetCycles = halfUp + CYCLE_ONE
				+ (pcSelected ? PC_EXTRA_DOUBLE : '0);
		end
		else
		begin
			targetCycles = atLeastTwo(totalCount
				+ (pcSelected ? PC_EXTRA_SINGLE : '0));
		end
	end
endmodule

// file: rtl/block_transfer_sequencer.sv
// Sequencer for multiple-register load and store instructions.
module block_transfer_sequencer
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clkEn,
	// Instruction
	input wire logic start,
	input wire logic condPass,
	input wire block_xfer_pkg::reg_list_t regList,
	input wire logic loadMultiple,
	input wire logic preIndex,
	input wire logic up,
	input wire logic writeBack,
	input wire logic userBank,
	input wire block_xfer_pkg::reg_idx_t baseRegisterIdx,
	input wire block_xfer_pkg::word_t baseRegisterValue,
	input wire block_xfer_pkg::word_t instrAddr,
	input wire logic doubleBw,
	// Instruction status
	output logic ready,
	output logic busy,
	output logic done,
	output logic aborted,
	// Register banks
	input wire block_xfer_pkg::reg_bank_t curRegs,
	input wire block_xfer_pkg::reg_bank_t userRegs,
	// Memory request
	output logic memReq,
	output logic memWrite,
	output logic memPair,
	output block_xfer_pkg::word_t memAddr,
	output block_xfer_pkg::word_t memWdata,
	// Memory answer
	input wire block_xfer_pkg::rsp_t readResponseControl,
	input wire block_xfer_pkg::word_t memRdata0,
	input wire block_xfer_pkg::word_t memRdata1,
	input wire logic memAbort,
	// Register writes
	output logic wr0En,
	output block_xfer_pkg::reg_idx_t wr0Idx,
	output block_xfer_pkg::word_t wr0Data,
	output logic wr1En,
	output block_xfer_pkg::reg_idx_t wr1Idx,
	output block_xfer_pkg::word_t wr1Data,
	output logic wrUser,
	output logic savedToCurrentStatus,
	output logic baseWrEn,
	output block_xfer_pkg::reg_idx_t baseWrIdx,
	output block_xfer_pkg::word_t baseWrData
);
	import block_xfer_pkg::*;

	typedef struct packed {
		seq_state_t state;
		logic ready;
		logic busy;
		logic done;
		logic aborted;
		logic memReq;
		logic memWrite;
		logic memPair;
		word_t memAddr;
		word_t memWdata;
		reg_idx_t curIdx0;
		reg_idx_t curIdx1;
		reg_list_t mask;
		logic loadMultiple;
		logic userBank;
		logic writeBack;
		logic doubleBw;
		logic statusCopyArm;
		word_t pcValue;
		word_t origBase;
		word_t finalBase;
		cycle_t elapsed;
		cycle_t target;
		logic wr0En;
		reg_idx_t wr0Idx;
		word_t wr0Data;
		logic wr1En;
		reg_idx_t wr1Idx;
		word_t wr1Data;
		logic wrUser;
		logic savedToCurrent;
		logic baseWrEn;
		reg_idx_t baseWrIdx;
		word_t baseWrData;
	} seq_regs_t;

	seq_regs_t r;
	seq_regs_t n;
	logic grant;
	logic takeTwo;
	reg_list_t leftMask;
	reg_list_t scanMask;
	reg_idx_t firstIdx;
	logic firstHit;
	reg_idx_t secondIdx;
	logic secondHit;
	cycle_t totalCount;
	cycle_t ordinaryCount;
	logic pcSelected;
	word_t startAddr;
	word_t finalBase;
	cycle_t targetCycles;
	word_t stepSize;
	word_t startPc;

	// The program counter always reads with its two low bits cleared.
	function automatic word_t pcClean(input word_t v);
		return v & PC_ALIGN_MASK;
	endfunction

	// Snapshots are taken before any base write, so a listed base reads
	// as its original value throughout the store.
	function automatic word_t storeWord(input reg_idx_t idx,
		input logic useUser, input word_t pcVal);
		if (idx == PROGRAM_COUNTER_IDX)
		begin
			return pcVal;
		end
		return useUser ? userRegs[idx] : curRegs[idx];
	endfunction

	// A short answer to a paired read takes one word and keeps the rest.
	assign grant = r.memReq && !memAbort && readResponseControl != RSP_NONE;
	assign takeTwo = grant && r.memPair && readResponseControl == RSP_TWO;
	assign leftMask = r.mask & ~(grant ? regBit(r.curIdx0) : '0)
		& ~(takeTwo ? regBit(r.curIdx1) : '0);
	assign scanMask = (r.state == ST_IDLE) ? regList : leftMask;
	assign stepSize = takeTwo ? PAIR_STEP : (grant ? WORD_STEP : NO_STEP);
	assign startPc = pcClean(instrAddr + PC_STORE_OFFSET);

	reg_list_scan scan
	(
		.regMask(scanMask),
		.firstIdx(firstIdx),
		.firstHit(firstHit),
		.secondIdx(secondIdx),
		.secondHit(secondHit),
		.totalCount(totalCount),
		.ordinaryCount(ordinaryCount),
		.pcSelected(pcSelected)
	);

	block_addr_calc calc
	(
		.baseValue(baseRegisterValue),
		.totalCount(totalCount),
		.ordinaryCount(ordinaryCount),
		.pcSelected(pcSelected),
		.preIndex(preIndex),
		.up(up),
		.loadMultiple(loadMultiple),
		.doubleBw(doubleBw),
		.startAddr(startAddr),
		.finalBase(finalBase),
		.targetCycles(targetCycles)
	);

	always_comb
	begin
		n = r;
		n.done = 1'b0;
		n.wr0En = 1'b0;
		n.wr1En = 1'b0;
		n.savedToCurrent = 1'b0;
		n.baseWrEn = 1'b0;
		case (r.state)
			ST_IDLE:
			begin
				if (start && !condPass)
				begin
					n.done = 1'b1;
					n.aborted = 1'b0;
				end
				else if (start)
				begin
					// An empty list would only pad cycles; it is never sent.
					n.state = ST_RUN;
					n.ready = 1'b0;
					n.busy = 1'b1;
					n.aborted = 1'b0;
					n.loadMultiple = loadMultiple;
					n.userBank = userBank;
					n.writeBack = writeBack;
					n.doubleBw = doubleBw;
					n.wrUser = userBank && loadMultiple && !pcSelected;
					n.statusCopyArm = userBank && loadMultiple;
					n.pcValue = startPc;
					n.origBase = baseRegisterValue;
					n.finalBase = finalBase;
					n.baseWrIdx = baseRegisterIdx;
					n.mask = regList;
					n.elapsed = CYCLE_ONE;
					n.target = targetCycles;
					n.memAddr = startAddr;
					n.memReq = firstHit;
					n.memWrite = !loadMultiple;
					n.memPair = loadMultiple && doubleBw && secondHit;
					n.curIdx0 = firstIdx;
					n.curIdx1 = secondIdx;
					n.memWdata = storeWord(firstIdx, userBank, startPc);
				end
			end
			ST_RUN:
			begin
				if (r.memReq && memAbort)
				begin
					// Remaining transfers are dropped and the base restored.
					n.state = ST_IDLE;
					n.memReq = 1'b0;
					n.memPair = 1'b0;
					n.busy = 1'b0;
					n.ready = 1'b1;
					n.done = 1'b1;
					n.aborted = 1'b1;
					n.baseWrEn = 1'b1;
					n.baseWrData = r.origBase;
				end
				else
				begin
					if (grant && r.loadMultiple)
					begin
						n.wr0En = 1'b1;
						n.wr0Idx = r.curIdx0;
						n.wr0Data = (r.curIdx0 == PROGRAM_COUNTER_IDX)
							? pcClean(memRdata0) : memRdata0;
						n.wr1En = takeTwo;
						n.wr1Idx = r.curIdx1;
						n.wr1Data = (r.curIdx1 == PROGRAM_COUNTER_IDX)
							? pcClean(memRdata1) : memRdata1;
						n.savedToCurrent = r.statusCopyArm
							&& (r.curIdx0 == PROGRAM_COUNTER_IDX
							|| (takeTwo && r.curIdx1 == PROGRAM_COUNTER_IDX));
					end
					n.mask = leftMask;
					n.memAddr = r.memAddr + stepSize;
					n.memReq = firstHit;
					n.memPair = r.loadMultiple && r.doubleBw && secondHit;
					n.curIdx0 = firstIdx;
					n.curIdx1 = secondIdx;
					n.memWdata = storeWord(firstIdx, r.userBank, r.pcValue);
					if (!firstHit && r.elapsed >= r.target)
					begin
						n.state = ST_IDLE;
						n.busy = 1'b0;
						n.ready = 1'b1;
						n.done = 1'b1;
						n.baseWrEn = r.writeBack;
						n.baseWrData = r.finalBase;
					end
					else if (r.elapsed < r.target)
					begin
						n.elapsed = r.elapsed + CYCLE_ONE;
					end
				end
			end
			default:
			begin
				n.state = ST_IDLE;
				n.busy = 1'b0;
				n.ready = 1'b1;
				n.memReq = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			r <= '0;
			r.state <= ST_IDLE;
			r.ready <= 1'b1;
		end
		else if (clkEn)
		begin
			r <= n;
		end
	end

	// Busy cycles counted apart from the sequencer, for checking only.
	cycle_t busyLen;
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			busyLen <= '0;
		end
		else if (clkEn)
		begin
			// Saturates so that a long wait can never wrap the count.
			if (!r.busy)
			begin
				busyLen <= '0;
			end
			else if (busyLen != '1)
			begin
				busyLen <= busyLen + CYCLE_ONE;
			end
		end
	end

	skip_no_xfer_a: assert property (@(posedge clk) disable iff (!rst_b)
		clkEn && r.ready && start && !condPass
		|=> done && !busy && !memReq && !baseWrEn)
		else $error("failed instruction made a transfer");
	pc_store_value_a: assert property (@(posedge clk) disable iff (!rst_b)
		clkEn && r.ready && start && condPass && !loadMultiple
		&& regList == 16'h8000
		|=> memReq && memWrite
		&& memWdata == (($past(instrAddr) + PC_STORE_OFFSET) & PC_ALIGN_MASK))
		else $error("stored program counter value wrong");
	ascend_order_a: assert property (@(posedge clk) disable iff (!rst_b)
		clkEn && memReq && $past(memReq) && $past(clkEn)
		&& wr0En |-> memAddr != $past(memAddr)
		&& (up_dir_ok(memAddr, $past(memAddr))))
		else $error("transfer order not ascending");
	low_bits_a: assert property (@(posedge clk) disable iff (!rst_b)
		clkEn && memReq && $past(memReq) |-> memAddr[1:0] == $past(memAddr[1:0]))
		else $error("low address bits changed");
	abort_restore_a: assert property (@(posedge clk) disable iff (!rst_b)
		clkEn && memReq && memAbort
		|=> baseWrEn && baseWrData == r.origBase && aborted && !memReq
		##1 !busy && !wr0En)
		else $error("abort did not restore the base");
	write_back_a: assert property (@(posedge clk) disable iff (!rst_b)
		done && !aborted && $past(busy) |-> baseWrEn == r.writeBack
		&& (!baseWrEn || baseWrData == r.finalBase))
		else $error("base write-back wrong");
	status_copy_a: assert property (@(posedge clk) disable iff (!rst_b)
		savedToCurrentStatus |-> (wr0En && wr0Idx == PROGRAM_COUNTER_IDX)
		|| (wr1En && wr1Idx == PROGRAM_COUNTER_IDX))
		else $error("status copy without program counter load");
	user_bank_a: assert property (@(posedge clk) disable iff (!rst_b)
		wr0En && wrUser |-> !savedToCurrentStatus)
		else $error("user bank load with status copy");
	pc_low_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
		wr0En && wr0Idx == PROGRAM_COUNTER_IDX |-> wr0Data[1:0] == 2'h0)
		else $error("program counter low bits written");
	min_cycles_a: assert property (@(posedge clk) disable iff (!rst_b)
		clkEn && r.busy && n.done && !n.aborted
		|-> busyLen + CYCLE_ONE >= r.target && r.target >= MIN_CYCLES)
		else $error("instruction ended before its cycle count");
	pair_load_a: assert property (@(posedge clk) disable iff (!rst_b)
		memPair |-> !memWrite && r.doubleBw)
		else $error("paired request outside a load");

	// Addresses of successive requests differ by one or two words.
	function automatic logic up_dir_ok(input word_t a, input word_t b);
		return (a - b == WORD_STEP) || (a - b == PAIR_STEP);
	endfunction

	assign ready = r.ready;
	assign busy = r.busy;
	assign done = r.done;
	assign aborted = r.aborted;
	assign memReq = r.memReq;
	assign memWrite = r.memWrite;
	assign memPair = r.memPair;
	assign memAddr = r.memAddr;
	assign memWdata = r.memWdata;
	assign wr0En = r.wr0En;
	assign wr0Idx = r.wr0Idx;
	assign wr0Data = r.wr0Data;
	assign wr1En = r.wr1En;
	assign wr1Idx = r.wr1Idx;
	assign wr1Data = r.wr1Data;
	assign wrUser = r.wrUser;
	assign savedToCurrentStatus = r.savedToCurrent;
	assign baseWrEn = r.baseWrEn;
	assign baseWrIdx = r.baseWrIdx;
	assign baseWrData = r.baseWrData;
endmodule

// file: rtl/reg_list_scan.sv
// Finds the two lowest selected registers of a list and counts the list.
module reg_list_scan
(
	// List to scan
	input wire block_xfer_pkg::reg_list_t regMask,
	// Two lowest selected registers
	output block_xfer_pkg::reg_idx_t firstIdx,
	output logic firstHit,
	output block_xfer_pkg::reg_idx_t secondIdx,
	output logic secondHit,
	// Counts
	output block_xfer_pkg::cycle_t totalCount,
	output block_xfer_pkg::cycle_t ordinaryCount,
	output logic pcSelected
);
	import block_xfer_pkg::*;

	logic [4:0] lo1;
	logic [4:0] lo2;

	always_comb
	begin
		lo1 = lowestSet(regMask);
		lo2 = lowestSet(regMask & ~regBit(lo1[3:0]));
		firstIdx = lo1[3:0];
		firstHit = lo1[4];
		secondIdx = lo2[3:0];
		secondHit = lo2[4];
		totalCount = '0;
		for (int i = 0; i <= LAST_REG; i++)
		begin
			totalCount = totalCount + cycle_t'(regMask[i]);
		end
		pcSelected = regMask[PROGRAM_COUNTER_IDX];
		ordinaryCount = totalCount - cycle_t'(pcSelected);
	end
endmodule

// file: tb/block_transfer_sequencer_tb.sv
// Self-checking bench of the block transfer sequencer.
module block_transfer_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import block_xfer_pkg::*;
	typedef struct {reg_idx_t idx; word_t addr; word_t data;} xfer_t;
	typedef struct {int cyc; int wbm; word_t bdata; logic ab;} note_t;
	logic clk, rst_b, clkEn, start, condPass, loadMultiple, preIndex, up;
	logic writeBack, userBank, doubleBw, ready, busy, done, aborted;
	logic memReq, memWrite, memPair, memAbort, wr0En, wr1En, wrUser;
	logic savedToCurrentStatus, baseWrEn, waitMode, singleMode;
	logic curLoad, curS, curPc;
	logic [4:0] abortAt;
	reg_list_t regList;
	reg_idx_t baseRegisterIdx, wr0Idx, wr1Idx, baseWrIdx;
	word_t baseRegisterValue, instrAddr, memAddr, memWdata, memRdata0;
	word_t memRdata1, wr0Data, wr1Data, baseWrData;
	reg_bank_t curRegs, userRegs;
	rsp_t readResponseControl;
	xfer_t xq[$];
	note_t dq[$];
	int num_errors = 0;
	int comparisons = 0;
	int busyCnt = 0;
	int cycles = 0;

	block_transfer_sequencer dut_u
	(
		.clk, .rst_b, .clkEn, .start, .condPass, .regList, .loadMultiple,
		.preIndex, .up, .writeBack, .userBank, .baseRegisterIdx,
		.baseRegisterValue, .instrAddr, .doubleBw, .ready, .busy, .done,
		.aborted, .curRegs, .userRegs, .memReq, .memWrite, .memPair,
		.memAddr, .memWdata, .readResponseControl, .memRdata0, .memRdata1,
		.memAbort, .wr0En, .wr0Idx, .wr0Data, .wr1En, .wr1Idx, .wr1Data,
		.wrUser, .savedToCurrentStatus, .baseWrEn, .baseWrIdx, .baseWrData
	);
	mem_model mem_u
	(
		.clk, .rst_b, .clkEn, .memReq, .memPair, .memAddr, .done,
		.waitMode, .singleMode, .abortAt, .readResponseControl,
		.memRdata0, .memRdata1, .memAbort
	);

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic end_sim();
		if (num_errors == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic cmpWord(input word_t got, input word_t exp, input string s);
		comparisons++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t %s: got %h expected %h", $time, s, got, exp);
		end
	endtask

	task automatic cmpBit(input logic got, input logic exp, input string s);
		cmpWord(word_t'(got), word_t'(exp), s);
	endtask

	task automatic chkWr(input reg_idx_t idx, input word_t data);
		xfer_t x;
		if (xq.size() == 0)
		begin
			cmpBit(1'b1, 1'b0, "unexpected register write");
			return;
		end
		x = xq.pop_front();
		cmpWord(word_t'(idx), word_t'(x.idx), "write index");
		cmpWord(data, x.data, "loaded value");
		cmpBit(wrUser, curS && !curPc, "user bank");
		// A paired load may carry the program counter in its upper lane.
		cmpBit(savedToCurrentStatus, curS && (idx == PROGRAM_COUNTER_IDX
			|| (wr1En === 1'b1 && wr1Idx == PROGRAM_COUNTER_IDX)),
			"status copy");
	endtask

	task automatic chkReq();
		if (xq.size() == 0)
		begin
			cmpBit(1'b1, 1'b0, "unexpected request");
			return;
		end
		cmpWord(memAddr, xq[0].addr, "address");
		cmpBit(memWrite, !curLoad, "direction");
		cmpBit(memPair, curLoad && doubleBw && xq.size() > 1, "pair");
		if (!curLoad)
		begin
			cmpWord(memWdata, xq[0].data, "stored value");
			void'(xq.pop_front());
		end
	endtask

	task automatic chkDone();
		note_t d;
		if (dq.size() == 0)
		begin
			cmpBit(1'b1, 1'b0, "unexpected done");
			return;
		end
		d = dq.pop_front();
		cmpBit(aborted, d.ab, "abort flag");
		if (d.cyc >= 0)
			cmpWord(word_t'(busyCnt), word_t'(d.cyc), "cycles");
		cmpBit(baseWrEn, d.wbm == 2, "base write");
		cmpBit(ready, 1'b1, "ready");
		if (baseWrEn === 1'b1)
		begin
			cmpWord(baseWrData, d.bdata, "base value");
			cmpWord(word_t'(baseWrIdx), word_t'(baseRegisterIdx),
				"base index");
		end
		cmpWord(word_t'(xq.size()), 32'h0000_0000, "left over");
		xq.delete();
	endtask

	always @(posedge clk)
	begin
		// Frozen cycles repeat the last outputs, so they are not looked at.
		if (rst_b === 1'b1 && clkEn === 1'b1)
		begin
			if (busy === 1'b1)
				busyCnt++;
			if (wr0En === 1'b1)
				chkWr(wr0Idx, wr0Data);
			if (wr1En === 1'b1)
				chkWr(wr1Idx, wr1Data);
			if (memReq === 1'b1 && memAbort !== 1'b1 &&
				readResponseControl !== RSP_NONE)
				chkReq();
			if (done === 1'b1)
			begin
				chkDone();
				busyCnt = 0;
			end
		end
	end

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			num_errors++;
			end_sim();
		end
	end

	// Flags are {load, pre, up, wb, user, dbl, cond, wait, single}.
	task automatic run(input logic [8:0] f, input reg_list_t lst,
		input word_t base, input logic [4:0] ab);
		int n, k, cyc;
		word_t a;
		xfer_t x;
		note_t d;
		n = $countones(lst);
		k = 0;
		a = f[6] ? base + (f[7] ? WORD_STEP : NO_STEP) :
			base - word_t'(4 * n) + (f[7] ? NO_STEP : WORD_STEP);
		@(negedge clk);
		{loadMultiple, preIndex, up, writeBack, userBank} = f[8:4];
		{doubleBw, condPass, waitMode, singleMode} = f[3:0];
		{curLoad, curS, curPc} = {f[8], f[4], lst[15]};
		{abortAt, regList, baseRegisterValue} = {ab, lst, base};
		instrAddr = $urandom();
		for (int i = 0; i < 16; i++)
		begin
			curRegs[i] = $urandom();
			userRegs[i] = $urandom();
		end
		curRegs[13] = base;
		for (int i = 0; i < 16; i++)
		begin
			if (lst[i] && f[2] && k < ab)
			begin
				x.idx = reg_idx_t'(i);
				x.addr = a;
				if (f[8])
					x.data = (a ^ 32'hC3C3_0000) &
						(i == 15 ? PC_ALIGN_MASK : 32'hFFFF_FFFF);
				else
					x.data = i == 15 ? (instrAddr + PC_STORE_OFFSET) &
						PC_ALIGN_MASK : f[4] ? userRegs[i] : curRegs[i];
				xq.push_back(x);
				k++;
				a += WORD_STEP;
			end
		end
		if (!f[2])
			cyc = 0;
		else if (f[1] || f[0] || ab != 5'h1F)
			cyc = -1;
		else if (!f[8])
			cyc = n < 2 ? 2 : n;
		else if (f[3])
			cyc = (n - lst[15] + 1) / 2 + 1 + 4 * lst[15];
		else
			cyc = n + 5 * lst[15] < 2 ? 2 : n + 5 * lst[15];
		d.cyc = cyc;
		d.ab = f[2] && ab != 5'h1F;
		d.wbm = !f[2] ? 0 : (f[5] || d.ab) ? 2 : 1;
		d.bdata = (f[5] && !d.ab) ? (f[6] ? base + word_t'(4 * n) :
			base - word_t'(4 * n)) : base;
		dq.push_back(d);
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		for (int t = 0; t < 300 && dq.size() > 0; t++)
			@(negedge clk);
		if (dq.size() > 0)
			cmpBit(1'b1, 1'b0, "no completion");
		dq.delete();
	endtask

	initial
	begin
		logic [8:0] f;
		reg_list_t l;
		{rst_b, clkEn, start, condPass, loadMultiple, preIndex} = 6'h01 << 4;
		{up, writeBack, userBank, doubleBw, waitMode, singleMode} = 6'h00;
		{abortAt, regList, baseRegisterValue} = {5'h1F, 48'h0};
		{instrAddr, curRegs, userRegs} = '0;
		baseRegisterIdx = 4'hD;
		void'($urandom(32'hb1c7));
		repeat (5) @(negedge clk);
		rst_b = 1'b1;
		run(9'b101101000, 16'h00A2, 32'h0000_1000, 5'h1F);
		for (int m = 0; m < 8; m++)
			run({3'(m), 6'b101100}, 16'h00A2, 32'h0000_1000, 5'h1F);
		run(9'b010011100, 16'h8005, 32'h0000_1800, 5'h1F);
		run(9'b101011100, 16'h8003, 32'h0000_1800, 5'h1F);
		run(9'b101011100, 16'h0330, 32'h0000_1800, 5'h1F);
		run(9'b101101100, 16'hFFFF, 32'h0000_2000, 5'h1F);
		run(9'b101101100, 16'h7FFF, 32'h0000_2000, 5'h1F);
		run(9'b101101100, 16'h8000, 32'h0000_2000, 5'h1F);
		run(9'b101100100, 16'h8001, 32'h0000_2000, 5'h1F);
		run(9'b101100100, 16'h0001, 32'h0000_2000, 5'h1F);
		run(9'b001101100, 16'hDFFF, 32'h0000_2000, 5'h1F);
		run(9'b001101100, 16'h0001, 32'h0000_2000, 5'h1F);
		run(9'b001101100, 16'hE000, 32'h0000_2000, 5'h1F);
		run(9'b011101100, 16'h0C06, 32'h0000_2002, 5'h1F);
		run(9'b100101100, 16'h0C06, 32'h0000_2003, 5'h1F);
		run(9'b101101111, 16'h0FF0, 32'h0000_3000, 5'h1F);
		run(9'b001101110, 16'h00FF, 32'h0000_3000, 5'h1F);
		run(9'b001100100, 16'h00F0, 32'h0000_4000, 5'h02);
		run(9'b101100100, 16'h0F0F, 32'h0000_4000, 5'h03);
		run(9'b100000100, 16'h0006, 32'h0000_4000, 5'h00);
		run(9'b001101100, 16'h8000, 32'h0000_2000, 5'h1F);
		fork
			run(9'b101101100, 16'h8000, 32'h0000_2000, 5'h1F);
			begin
				repeat (3) @(negedge clk);
				clkEn = 1'b0;
				repeat (3) @(negedge clk);
				clkEn = 1'b1;
			end
		join
		for (int i = 0; i < 24; i++)
		begin
			f = 9'($urandom()) | 9'b000000100;
			if (f[4])
				f[5] = 1'b0;
			l = reg_list_t'($urandom()) & 16'hDFFF;
			if (l == 16'h0000)
				l = 16'h0001;
			run(f, l, $urandom(), 5'h1F);
		end
		end_sim();
	end
endmodule

// file: tb/mem_model.sv
// Behavioural memory system that answers, waits, splits pairs and aborts.
module mem_model
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clkEn,
	// Request from the sequencer
	input wire logic memReq,
	input wire logic memPair,
	input wire block_xfer_pkg::word_t memAddr,
	input wire logic done,
	// Behaviour chosen by the bench
	input wire logic waitMode,
	input wire logic singleMode,
	input wire logic [4:0] abortAt,
	// Answer
	output block_xfer_pkg::rsp_t readResponseControl,
	output block_xfer_pkg::word_t memRdata0,
	output block_xfer_pkg::word_t memRdata1,
	output logic memAbort
);
	timeunit 1ns;
	timeprecision 1ps;
	import block_xfer_pkg::*;
	logic go;
	logic tick;
	logic answer;
	logic [4:0] reqCount;
	// Data follows the full address, so a wrong word or a rotation shows.
	// Nothing is answered or aborted while the sequencer is frozen.
	assign memAbort = memReq && clkEn && reqCount == abortAt;
	assign answer = memReq && clkEn && go && !memAbort;
	assign readResponseControl = !answer ? RSP_NONE :
		(memPair && !singleMode) ? RSP_TWO : RSP_ONE;
	assign memRdata0 = answer ? memAddr ^ 32'hC3C3_0000 : {32{tick}};
	// Unanswered lanes toggle each cycle, so stale data is never trusted.
	assign memRdata1 = readResponseControl == RSP_TWO ?
		(memAddr + WORD_STEP) ^ 32'hC3C3_0000 : {32{~tick}};
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			go <= 1'b1;
			tick <= 1'b0;
			reqCount <= 5'h00;
		end
		else
		begin
			tick <= ~tick;
			go <= !waitMode || 1'($urandom());
			reqCount <= done ? 5'h00 : reqCount + 5'(answer);
		end
	end
endmodule
